// ### utie_top.sv
// Purpose: Interrupt enable register for timer and USB sources
// Assumes: AXI4-Lite master keeps one read and one write outstanding
// Notes:   Requests lag sources and mask writes by one cycle
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE_01: Bit 5 gates millisecond timer interrupt
// RULE_02: Bit 4 gates USB activity interrupt
// RULE_03: Bit 3 gates USB bus reset interrupt
// RULE_04: Bit 2 gates endpoint 2 interrupt
// RULE_05: Bit 1 gates endpoint 1 interrupt
// RULE_06: Bit 0 gates endpoint 0 interrupt
// RULE_07: Bit 6 gates interval timer interrupt
// RULE_08: Masked source raises no request
module utie_top (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic SRC_EP0,
  input wire logic SRC_EP1,
  input wire logic SRC_EP2,
  input wire logic SRC_BUS_RESET,
  input wire logic SRC_BUS_ACTIVE,
  input wire logic SRC_MS_TICK,
  input wire logic SRC_PIT,
  output logic [utie_pkg::UTIE_NSRC-1:0] REQ_OUT,
  output logic IRQ
);
  import utie_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] enable_reg, enable_next;       // Source gate mask
  logic [6:0] status_reg, status_next;       // Sticky gated events
  logic [6:0] irqen_reg, irqen_next;         // Line enable
  logic [6:0] gated_prev_reg, gated_prev_next; // Edge detect
  logic irq_reg, irq_next;                   // Registered line
  logic aw_held_reg, aw_held_next;           // Address captured
  logic [11:0] aw_addr_reg, aw_addr_next;
  logic w_held_reg, w_held_next;             // Data captured
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic do_write;                            // Both halves present
  logic [6:0] clr_bits;                      // Clear strobes
  logic [6:0] rise;                          // New gated events
  utie_gate_if gif ();

  // Offset decode shared by read and write paths
  function automatic logic utie_mapped(input logic [11:0] a);
    utie_mapped = (a == UTIE_OFF_ENABLE) || (a == UTIE_OFF_RAW) ||
                  (a == UTIE_OFF_STATUS) || (a == UTIE_OFF_CLEAR) ||
                  (a == UTIE_OFF_IRQEN);
  endfunction

  // ----------------------------------------------------------------
  // Source bundle and gate
  // ----------------------------------------------------------------
  always_comb begin
    gif.raw = '0;
    gif.raw[UTIE_BIT_MS] = SRC_MS_TICK;        // see RULE_01
    gif.raw[UTIE_BIT_ACTIVE] = SRC_BUS_ACTIVE; // see RULE_02
    gif.raw[UTIE_BIT_BUSRST] = SRC_BUS_RESET;  // see RULE_03
    gif.raw[UTIE_BIT_EP2] = SRC_EP2;           // see RULE_04
    gif.raw[UTIE_BIT_EP1] = SRC_EP1;           // see RULE_05
    gif.raw[UTIE_BIT_EP0] = SRC_EP0;           // see RULE_06
    gif.raw[UTIE_BIT_PIT] = SRC_PIT;           // see RULE_07
  end
  // Bit 7 is reserved, never reaches the gate
  assign gif.mask = enable_reg[UTIE_NSRC-1:0];

  utie_gate u_gate (
    .clk(CLK),
    .rst_n(RST_N),
    .gi(gif.gate)
  );

  // ----------------------------------------------------------------
  // Write channel: address and data accepted in either order
  // ----------------------------------------------------------------
  always_comb begin
    aw_held_next = aw_held_reg;
    aw_addr_next = aw_addr_reg;
    w_held_next = w_held_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    // Capture each half once, refused while a response waits
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_held_next = 1'b1;
      aw_addr_next = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_held_next = 1'b1;
      w_data_next = S_AXI_WDATA;
      w_strb_next = S_AXI_WSTRB;
    end
    // Perform the write once both halves are held
    if (do_write) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = utie_mapped(aw_addr_reg) ? UTIE_RESP_OKAY : UTIE_RESP_SLVERR;
    end else if (bvalid_reg && S_AXI_BREADY) begin
      bvalid_next = 1'b0;
    end
  end
  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  assign S_AXI_AWREADY = !aw_held_reg && !bvalid_reg;
  assign S_AXI_WREADY = !w_held_reg && !bvalid_reg;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always_comb begin
    enable_next = enable_reg;
    irqen_next = irqen_reg;
    clr_bits = '0;
    // Only byte lane 0 carries fields; upper lanes ignored
    if (do_write && w_strb_reg[0]) begin
      case (aw_addr_reg)
        UTIE_OFF_ENABLE: begin
          // Reserved bit 7 stays zero
          enable_next = w_data_reg[7:0] & UTIE_WRITE_MASK; // see RULE_08
        end
        UTIE_OFF_IRQEN: begin
          irqen_next = w_data_reg[6:0];
        end
        UTIE_OFF_CLEAR: begin
          clr_bits = w_data_reg[6:0];
        end
        default: begin
          enable_next = enable_reg;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sticky events and interrupt line
  // ----------------------------------------------------------------
  always_comb begin
    rise = gif.gated & ~gated_prev_reg;
    gated_prev_next = gif.gated;
    // A new event wins over a clear in the same cycle
    status_next = (status_reg & ~clr_bits) | rise;
    irq_next = |(status_next & irqen_next);
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  always_comb begin
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_next = 1'b1;
      rresp_next = utie_mapped(S_AXI_ARADDR) ? UTIE_RESP_OKAY : UTIE_RESP_SLVERR;
      case (S_AXI_ARADDR)
        UTIE_OFF_ENABLE: rdata_next = {24'h000000, enable_reg};
        UTIE_OFF_RAW: rdata_next = {25'h0000000, gif.raw};
        UTIE_OFF_STATUS: rdata_next = {25'h0000000, status_reg};
        UTIE_OFF_IRQEN: rdata_next = {25'h0000000, irqen_reg};
        // Clear register is write only
        default: rdata_next = 32'h00000000;
      endcase
    end else if (rvalid_reg && S_AXI_RREADY) begin
      rvalid_next = 1'b0;
    end
  end
  assign S_AXI_ARREADY = !rvalid_reg;

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      enable_reg <= UTIE_ENABLE_RST;
      status_reg <= '0;
      irqen_reg <= '0;
      gated_prev_reg <= '0;
      irq_reg <= 1'b0;
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_held_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= UTIE_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= UTIE_RESP_OKAY;
      rdata_reg <= '0;
    end else begin
      enable_reg <= enable_next;
      status_reg <= status_next;
      irqen_reg <= irqen_next;
      gated_prev_reg <= gated_prev_next;
      irq_reg <= irq_next;
      aw_held_reg <= aw_held_next;
      aw_addr_reg <= aw_addr_next;
      w_held_reg <= w_held_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign REQ_OUT = gif.gated; // see RULE_08
  assign IRQ = irq_reg;
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RRESP = rresp_reg;
  assign S_AXI_RDATA = rdata_reg;
endmodule
`default_nettype wire

// ### utie_pkg.sv
// Purpose: Constants for the USB and timer interrupt enable block
// Assumes: AXI4-Lite register access, 32-bit data
// Notes:   Offsets are byte addresses, one word each
package utie_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] UTIE_OFF_ENABLE = 12'h000; // Source gate mask
  localparam logic [11:0] UTIE_OFF_RAW = 12'h004; // Live source levels
  localparam logic [11:0] UTIE_OFF_STATUS = 12'h008; // Sticky gated events
  localparam logic [11:0] UTIE_OFF_CLEAR = 12'h00C; // Write one to clear
  localparam logic [11:0] UTIE_OFF_IRQEN = 12'h010; // Event to line enable
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int UTIE_BIT_EP0 = 0;
  localparam int UTIE_BIT_EP1 = 1;
  localparam int UTIE_BIT_EP2 = 2;
  localparam int UTIE_BIT_BUSRST = 3;
  localparam int UTIE_BIT_ACTIVE = 4;
  localparam int UTIE_BIT_MS = 5;
  localparam int UTIE_BIT_PIT = 6;
  localparam int UTIE_NSRC = 7; // Bit 7 is reserved
  // ----------------------------------------------------------------
  // Reset values and bus codes
  // ----------------------------------------------------------------
  localparam logic [7:0] UTIE_ENABLE_RST = 8'h00;
  localparam logic [7:0] UTIE_WRITE_MASK = 8'h7F;
  localparam logic [1:0] UTIE_RESP_OKAY = 2'h0;
  localparam logic [1:0] UTIE_RESP_SLVERR = 2'h2;
endpackage

// ### utie_gate_if.sv
// Purpose: Carries raw sources, mask and gated requests between modules
// Assumes: One clock domain
// Notes:   Width is the number of gated sources
`timescale 1ns/1ps
`default_nettype none
interface utie_gate_if;
  logic [6:0] raw;   // Ungated requests
  logic [6:0] mask;  // Enable bits
  logic [6:0] gated; // Forwarded requests
  modport ctrl (output raw, output mask, input gated);
  modport gate (input raw, input mask, output gated);
endinterface
`default_nettype wire

// ### utie_gate.sv
// Purpose: Per-source AND gate, registered
// Assumes: Sources synchronous to CLK
// Notes:   One cycle latency from source or mask to request
`timescale 1ns/1ps
`default_nettype none
module utie_gate (
  input wire logic clk,
  input wire logic rst_n,
  utie_gate_if.gate gi
);
  import utie_pkg::*;
  logic [UTIE_NSRC-1:0] gated_reg;
  logic [UTIE_NSRC-1:0] gated_next;
  // ----------------------------------------------------------------
  // Gating: a cleared enable bit blocks its source entirely
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < UTIE_NSRC; g++) begin : g_src
      always_comb begin
        gated_next[g] = gi.raw[g] & gi.mask[g]; // see RULE_08
      end
    end
  endgenerate
  // Register stage keeps requests glitch free
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gated_reg <= '0;
    end else begin
      gated_reg <= gated_next;
    end
  end
  assign gi.gated = gated_reg;
endmodule
`default_nettype wire

// ### utie_monitor.sv
// Purpose: Port-level checks of the request gate
// Assumes: One clock, bound to utie_top from the bench top
// Notes:   The enable bits sit inside, so checks tie requests to sources
`timescale 1ns/1ps
`default_nettype none
module utie_monitor (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic SRC_EP0,
  input wire logic SRC_EP1,
  input wire logic SRC_EP2,
  input wire logic SRC_BUS_RESET,
  input wire logic SRC_BUS_ACTIVE,
  input wire logic SRC_MS_TICK,
  input wire logic SRC_PIT,
  input wire logic [utie_pkg::UTIE_NSRC-1:0] REQ_OUT,
  input wire logic IRQ
);
  import utie_pkg::*;
  // ------------------------------------------------------------
  // Requests lag their source by one edge
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  a_ms_gate: assert property (REQ_OUT[5] |-> $past(SRC_MS_TICK)) else $error("ms request without source");
  a_active_gate: assert property ($rose(REQ_OUT[4]) |-> $past(SRC_BUS_ACTIVE)) else $error("activity request bad");
  a_busrst_gate: assert property (REQ_OUT[3] |-> $past(SRC_BUS_RESET)) else $error("bus reset request bad");
  a_ep2_gate: assert property (REQ_OUT[2] |-> $past(SRC_EP2)) else $error("ep2 request bad");
  a_ep1_gate: assert property (REQ_OUT[1] |-> $past(SRC_EP1)) else $error("ep1 request bad");
  a_ep0_gate: assert property (REQ_OUT[0] |-> $past(SRC_EP0)) else $error("ep0 request bad");
  a_pit_gate: assert property (!SRC_PIT |=> !REQ_OUT[6]) else $error("interval request bad");
  a_quiet_idle: assert property ({SRC_PIT, SRC_MS_TICK, SRC_BUS_ACTIVE, SRC_BUS_RESET, SRC_EP2, SRC_EP1, SRC_EP0} == 7'h00
    |=> REQ_OUT == 7'h00) else $error("request with no source");
  // Main scenarios reached
  c_ms_req: cover property (REQ_OUT[5]);
  c_irq_up: cover property ($rose(IRQ));
  c_pit_req: cover property (REQ_OUT[6]);
endmodule
`default_nettype wire

// ### tb_usb_timer_irq_enable.sv
// Purpose: Self-checking bench for the interrupt enable block
// Assumes: AXI4-Lite master tasks, one transfer at a time
// Notes:   Ready is looked at on the falling edge, stable until the next rise
`timescale 1ns/1ps
`default_nettype none
module tb_usb_timer_irq_enable;
  import utie_pkg::*;
  logic CLK = 0, RST_N = 0;
  logic [11:0] aw_a = 12'h000, ar_a = 12'h000;
  logic [31:0] wd = 32'h0, rd;
  logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic aw_r, w_r, ar_r, bv, rv, irq;
  logic [1:0] br, rr;
  logic [6:0] src = 7'h00, req; // Source levels, bit order as REQ_OUT
  int bad_count = 0, n_tests = 0;
  utie_top dut (.CLK(CLK), .RST_N(RST_N), .S_AXI_AWADDR(aw_a), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(aw_r),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(w_r), .S_AXI_BRESP(br),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_ARADDR(ar_a), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(ar_r),
    .S_AXI_RDATA(rd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .SRC_EP0(src[0]),
    .SRC_EP1(src[1]), .SRC_EP2(src[2]), .SRC_BUS_RESET(src[3]), .SRC_BUS_ACTIVE(src[4]),
    .SRC_MS_TICK(src[5]), .SRC_PIT(src[6]), .REQ_OUT(req), .IRQ(irq));
  always #5 CLK = ~CLK; // 100 MHz
  // ------------------------------------------------------------
  // Report and compare helpers
  // ------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      bad_count++;
    end
  endtask
  // Bounded wait ran out: the run cannot go on
  task automatic tmo(input int n);
    if (n >= 40) begin
      $display("wrong value handshake expected done seen timeout");
      bad_count++;
      final_report();
    end
  endtask
  // ------------------------------------------------------------
  // Bus master tasks
  // ------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic pa, pw, ta, tw;
    n = 0; pa = 1; pw = 1;
    @(posedge CLK);
    aw_a <= a; wd <= d; awv <= 1; wv <= 1; bry <= 1;
    while ((pa | pw) && n < 40) begin
      @(negedge CLK);
      ta = pa & aw_r; tw = pw & w_r;
      @(posedge CLK);
      if (ta) begin
        pa = 0; awv <= 0;
      end
      if (tw) begin
        pw = 0; wv <= 0;
      end
      n++;
    end
    tmo(n);
    // Response arrives some edges later, BREADY held meanwhile
    while (n < 40) begin
      @(negedge CLK);
      if (bv === 1'b1) break;
      n++;
    end
    tmo(n);
    r = br;
    @(posedge CLK);
    bry <= 0;
  endtask
  task automatic rdr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge CLK);
    ar_a <= a; arv <= 1; rry <= 1;
    while (n < 40) begin
      @(negedge CLK);
      if (ar_r === 1'b1) break;
      n++;
    end
    tmo(n);
    @(posedge CLK);
    arv <= 0;
    while (n < 40) begin
      @(negedge CLK);
      if (rv === 1'b1) break;
      n++;
    end
    tmo(n);
    d = rd; r = rr;
    @(posedge CLK);
    rry <= 0;
  endtask
  // Drive sources, let request logic settle, then compare at a falling edge
  task automatic src_req(input logic [6:0] s, input logic [6:0] exp, input string nm);
    @(posedge CLK);
    src <= s;
    repeat (3) @(posedge CLK);
    @(negedge CLK);
    chk(nm, {25'h0, exp}, {25'h0, req});
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset_masked();
    logic [31:0] d;
    logic [1:0] r;
    rdr(UTIE_OFF_ENABLE, d, r);
    chk("enable reset", 32'h0, d);
    src_req(7'h7F, 7'h00, "req all masked");
  endtask
  // One enable bit at a time: only its own pin may pass
  task automatic t_bit_gates();
    logic [1:0] r;
    for (int i = 0; i < 7; i++) begin
      wr(UTIE_OFF_ENABLE, 32'h1 << i, r);
      chk("enable bresp", {30'h0, UTIE_RESP_OKAY}, {30'h0, r});
      src_req(7'h7F, 7'h01 << i, "req one open");
      src_req(7'h7F & ~(7'h01 << i), 7'h00, "req own pin low");
    end
  endtask
  task automatic t_readback();
    logic [31:0] d;
    logic [1:0] r;
    wr(UTIE_OFF_ENABLE, 32'hFF, r);
    rdr(UTIE_OFF_ENABLE, d, r);
    chk("enable readback", 32'h7F, d);
    rdr(12'h020, d, r);
    chk("unmapped rresp", {30'h0, UTIE_RESP_SLVERR}, {30'h0, r});
    rdr(UTIE_OFF_RAW, d, r);
    chk("raw levels", 32'h3F, d);
    wr(12'h020, 32'h1, r);
    chk("unmapped bresp", {30'h0, UTIE_RESP_SLVERR}, {30'h0, r});
  endtask
  // Masked event leaves no status; enabled one raises, masks and clears the line
  task automatic t_irq();
    logic [31:0] d;
    logic [1:0] r;
    wr(UTIE_OFF_CLEAR, 32'h7F, r);
    wr(UTIE_OFF_ENABLE, 32'h20, r);
    wr(UTIE_OFF_IRQEN, 32'h7F, r);
    src_req(7'h01, 7'h00, "req ep0 masked");
    src_req(7'h20, 7'h20, "req ms open");
    src_req(7'h00, 7'h00, "req ms low");
    rdr(UTIE_OFF_STATUS, d, r);
    chk("status ms only", 32'h20, d);
    chk("irq up", 32'h1, {31'h0, irq});
    wr(UTIE_OFF_IRQEN, 32'h00, r);
    repeat (2) @(posedge CLK);
    @(negedge CLK);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(UTIE_OFF_IRQEN, 32'h20, r);
    wr(UTIE_OFF_CLEAR, 32'h20, r);
    repeat (2) @(posedge CLK);
    @(negedge CLK);
    chk("irq cleared", 32'h0, {31'h0, irq});
  endtask
  initial begin
    repeat (10) @(posedge CLK);
    RST_N <= 1;
    t_reset_masked();
    t_bit_gates();
    t_readback();
    t_irq();
    final_report();
  end
endmodule
bind utie_top utie_monitor mon (.CLK(CLK), .RST_N(RST_N), .SRC_EP0(SRC_EP0), .SRC_EP1(SRC_EP1),
  .SRC_EP2(SRC_EP2), .SRC_BUS_RESET(SRC_BUS_RESET), .SRC_BUS_ACTIVE(SRC_BUS_ACTIVE),
  .SRC_MS_TICK(SRC_MS_TICK), .SRC_PIT(SRC_PIT), .REQ_OUT(REQ_OUT), .IRQ(IRQ));
`default_nettype wire
